// [logic/rtwm_top.sv]
// reload timer with guard mode, reached over apb
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module rtwm_top
  import rtwm_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtwm_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [rtwm_pkg::APB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [rtwm_pkg::APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // time-base tick
  input wire logic time_base_clock,
  // events
  output logic overflow_irq_flag,
  output logic system_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] timer_count_ff;
  logic [7:0] timer_reload_value_ff;
  logic [2:0] clock_select_ff;
  logic reload_run_ff;
  rtwm_mode_e mode_ff;
  logic guard_counting_ff;
  logic next_refresh_code_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [APB_DATA_W-1:0] prdata_ff;
  logic irq_ff;
  logic sysrst_ff;

  // decoded bus terms
  logic access;
  logic commit;
  logic wr_en;
  logic hit_count;
  logic hit_reload;
  logic hit_control;
  logic mapped;
  logic [7:0] wbyte;
  logic [APB_DATA_W-1:0] nxt_prdata;

  // timer terms
  logic count_tick;
  logic guard;
  logic counting;
  logic overflow;
  logic wr_count;
  logic wr_reload;
  logic wr_control;
  logic code_start;
  logic code_alt;
  logic refresh;
  logic [7:0] control_view;

  ////////////////////////////////////////////////////////////////////////////
  // count clock enable
  rtwm_prescaler u_prescaler (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .time_base_clock(time_base_clock),
    .clock_select(clock_select_ff),
    .count_tick(count_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  // access phase lasts two cycles; the second one commits
  assign access = psel && penable;
  assign commit = access && pready_ff;
  assign wr_en = commit && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];

  // address matching, word aligned
  assign hit_count = (paddr == OFS_COUNT);
  assign hit_reload = (paddr == OFS_RELOAD);
  assign hit_control = (paddr == OFS_CONTROL);
  assign mapped = hit_count || hit_reload || hit_control;

  // write strobes per register
  assign wr_count = wr_en && hit_count;
  assign wr_reload = wr_en && hit_reload;
  assign wr_control = wr_en && hit_control;

  ////////////////////////////////////////////////////////////////////////////
  // timer control terms
  assign guard = (mode_ff == RTWM_MODE_GUARD);
  // reload mode runs on the run bit, guard mode after start
  assign counting = guard ? guard_counting_ff : reload_run_ff;
  assign overflow = counting && count_tick &&
                    (timer_count_ff == CNT_TOP);

  // refresh code recognition on count writes in guard mode
  assign code_start = (wbyte[3:0] == CODE_START);
  assign code_alt = (wbyte[3:0] == CODE_ALT);
  // expected code: flag low wants 3, flag high wants C
  assign refresh = guard && guard_counting_ff && wr_count &&
                   (next_refresh_code_ff ? code_alt : code_start);

  // control read view
  always_comb begin
    control_view = 8'h00;
    control_view[CTL_SEL_MSB:CTL_SEL_LSB] = clock_select_ff;
    control_view[CTL_RUN_BIT] = reload_run_ff;
    control_view[CTL_ONE_BIT] = 1'b1;
    control_view[CTL_GCNT_BIT] = guard && guard_counting_ff;
    control_view[CTL_NEXT_BIT] = guard && next_refresh_code_ff;
    control_view[CTL_MODE_BIT] = guard;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: pready rises in the second access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= access && !pready_ff;
    end
  end

  // read data mux, live count included
  always_comb begin
    nxt_prdata = '0;
    if (hit_count) begin
      nxt_prdata[7:0] = timer_count_ff;
    end else if (hit_reload) begin
      nxt_prdata[7:0] = timer_reload_value_ff;
    end else if (hit_control) begin
      nxt_prdata[7:0] = control_view;
    end
  end

  // read data captured in the first access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_ff <= '0;
    end else if (ce && access && !pready_ff) begin
      prdata_ff <= pwrite ? '0 : nxt_prdata;
    end
  end

  // error for unmapped addresses, shown with pready
  always_ff @(posedge clk) begin
    if (srst) begin
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pslverr_ff <= access && !pready_ff && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode bit: set by a control write, cleared only by reset
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_ff <= RTWM_MODE_RELOAD;
    end else if (ce && wr_control && wbyte[CTL_MODE_BIT]) begin
      mode_ff <= RTWM_MODE_GUARD;
    end
  end

  // clock select: frozen once guard mode is in force
  always_ff @(posedge clk) begin
    if (srst) begin
      clock_select_ff <= CTL_RESET[CTL_SEL_MSB:CTL_SEL_LSB];
    end else if (ce && wr_control && !guard) begin
      // same write may also set the mode bit
      clock_select_ff <= wbyte[CTL_SEL_MSB:CTL_SEL_LSB];
    end
  end

  // run bit: writable in both modes, steers only reload mode
  always_ff @(posedge clk) begin
    if (srst) begin
      reload_run_ff <= CTL_RESET[CTL_RUN_BIT];
    end else if (ce && wr_control) begin
      reload_run_ff <= wbyte[CTL_RUN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // guard start flag: first code-3 write in guard mode
  always_ff @(posedge clk) begin
    if (srst) begin
      guard_counting_ff <= CTL_RESET[CTL_GCNT_BIT];
    end else if (ce && guard && wr_count && code_start) begin
      guard_counting_ff <= 1'b1;
    end
  end

  // next expected code: after start expect C, then alternate
  always_ff @(posedge clk) begin
    if (srst) begin
      next_refresh_code_ff <= 1'b0;
    end else if (ce) begin
      if (guard && !guard_counting_ff && wr_count && code_start) begin
        next_refresh_code_ff <= 1'b1;
      end else if (refresh) begin
        next_refresh_code_ff <= !next_refresh_code_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reload register
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_reload_value_ff <= CNT_RESET;
    end else if (ce && !guard) begin
      // guard mode makes it read-only
      if (wr_count) begin
        timer_reload_value_ff <= wbyte;
      end else if (wr_reload) begin
        timer_reload_value_ff <= wbyte;
      end
    end
  end

  // counter: software write, refresh, reload or increment
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_count_ff <= CNT_RESET;
    end else if (ce) begin
      if (!guard && wr_count) begin
        // write wins over a same-cycle count
        timer_count_ff <= wbyte;
      end else if (refresh) begin
        timer_count_ff <= timer_reload_value_ff;
      end else if (overflow && !guard) begin
        timer_count_ff <= timer_reload_value_ff;
      end else if (counting && count_tick) begin
        // guard-mode count writes never land here
        timer_count_ff <= timer_count_ff + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow events, one cycle each
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= overflow && !guard;
    end else begin
      irq_ff <= 1'b0;
    end
  end

  // reset request in guard mode; refresh in same cycle saves it
  always_ff @(posedge clk) begin
    if (srst) begin
      sysrst_ff <= 1'b0;
    end else if (ce) begin
      sysrst_ff <= overflow && guard && !refresh;
    end else begin
      sysrst_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff; // set only in the cycle that pready stands
  assign overflow_irq_flag = irq_ff;
  assign system_reset_req = sysrst_ff;

endmodule
`default_nettype wire

// [shared/rtwm_pkg.sv]
// constants for the reload timer with guard (watchdog) mode
`default_nettype none
package rtwm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] OFS_COUNT = 12'h000;
  localparam logic [11:0] OFS_RELOAD = 12'h004;
  localparam logic [11:0] OFS_CONTROL = 12'h008;

  ////////////////////////////////////////////////////////////////////////////
  // control register field positions
  localparam int unsigned CTL_SEL_LSB = 0;
  localparam int unsigned CTL_SEL_MSB = 2;
  localparam int unsigned CTL_RUN_BIT = 3;
  localparam int unsigned CTL_ONE_BIT = 4;
  localparam int unsigned CTL_GCNT_BIT = 5;
  localparam int unsigned CTL_NEXT_BIT = 6;
  localparam int unsigned CTL_MODE_BIT = 7;

  // control value after any system reset
  localparam logic [7:0] CTL_RESET = 8'h10;
  // counter and reload have no defined reset; zero is used
  localparam logic [7:0] CNT_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // refresh codes, low nibble only
  localparam logic [3:0] CODE_START = 4'h3;
  localparam logic [3:0] CODE_ALT = 4'hC;

  // clock select codes and their divide masks
  localparam logic [2:0] SEL_DIV1 = 3'h0;
  localparam logic [2:0] SEL_DIV2 = 3'h1;
  localparam logic [2:0] SEL_DIV4 = 3'h2;
  localparam logic [2:0] SEL_DIV8 = 3'h3;
  localparam logic [2:0] SEL_DIV32 = 3'h4;
  localparam logic [2:0] SEL_DIV256 = 3'h5;
  localparam logic [7:0] MASK_DIV1 = 8'h00;
  localparam logic [7:0] MASK_DIV2 = 8'h01;
  localparam logic [7:0] MASK_DIV4 = 8'h03;
  localparam logic [7:0] MASK_DIV8 = 8'h07;
  localparam logic [7:0] MASK_DIV32 = 8'h1F;
  localparam logic [7:0] MASK_DIV256 = 8'hFF;

  // counter value that overflows on the next count
  localparam logic [7:0] CNT_TOP = 8'hFF;

  // operating modes
  typedef enum logic {
    RTWM_MODE_RELOAD,
    RTWM_MODE_GUARD
  } rtwm_mode_e;

endpackage
`default_nettype wire

// [logic/rtwm_prescaler.sv]
// count clock selector: divides the time-base tick by the chosen ratio
`default_nettype none
module rtwm_prescaler
  import rtwm_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // time-base tick and select
  input wire logic time_base_clock,
  input wire logic [2:0] clock_select,
  // one-cycle count enable
  output logic count_tick
);

  logic [7:0] div_ff;
  logic [7:0] mask;
  logic count_tick_ff;

  // divide mask per select code; prohibited codes never tick
  always_comb begin
    mask = MASK_DIV1;
    case (clock_select)
      SEL_DIV1: mask = MASK_DIV1;
      SEL_DIV2: mask = MASK_DIV2;
      SEL_DIV4: mask = MASK_DIV4;
      SEL_DIV8: mask = MASK_DIV8;
      SEL_DIV32: mask = MASK_DIV32;
      SEL_DIV256: mask = MASK_DIV256;
      default: mask = MASK_DIV1;
    endcase
  end

  // free-running divider of time-base ticks
  always_ff @(posedge clk) begin
    if (srst) begin
      div_ff <= 8'h00;
    end else if (ce && time_base_clock) begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // tick when all masked divider bits are ones
  always_ff @(posedge clk) begin
    if (srst) begin
      count_tick_ff <= 1'b0;
    end else if (ce) begin
      count_tick_ff <= time_base_clock && ((div_ff & mask) == mask) &&
                       (clock_select <= SEL_DIV256);
    end
  end

  assign count_tick = count_tick_ff;

endmodule
`default_nettype wire

// [bench/rtwm_props.sv]
// port-level checks for the reload timer with guard mode
`default_nettype none
module rtwm_props
  import rtwm_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtwm_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [rtwm_pkg::APB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [rtwm_pkg::APB_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // tick and events
  input wire logic time_base_clock,
  input wire logic overflow_irq_flag,
  input wire logic system_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic done, rd_ctl, rd_rel, wr_ok, guard_ff, ctl_wr_ff;
  logic [7:0] rl_ff;
  logic [2:0] since_ff;
  ////////////////////////////////////////////////////////////////////////////
  // completed transfers
  assign done = psel && penable && pready;
  assign rd_ctl = done && !pwrite && paddr == OFS_CONTROL;
  assign rd_rel = done && !pwrite && paddr == OFS_RELOAD;
  assign wr_ok = done && pwrite && pstrb[0] && !pslverr;
  // mode shadow: set by a control write with the mode bit, kept to reset
  always_ff @(posedge clk) begin
    if (srst) guard_ff <= 1'b0;
    else if (wr_ok && paddr == OFS_CONTROL && pwdata[7]) guard_ff <= 1'b1;
  end
  // marks any control write since reset
  always_ff @(posedge clk) begin
    if (srst) ctl_wr_ff <= 1'b0;
    else if (done && pwrite && paddr == OFS_CONTROL) ctl_wr_ff <= 1'b1;
  end
  // reload shadow: count and reload writes land here in reload mode
  always_ff @(posedge clk) begin
    if (srst) rl_ff <= CNT_RESET;
    else if (wr_ok && !guard_ff && paddr != OFS_CONTROL)
      rl_ff <= pwdata[7:0];
  end
  // cycles since the last time-base tick, saturating
  always_ff @(posedge clk) begin
    if (srst || time_base_clock) since_ff <= 3'h0;
    else if (since_ff != 3'h7) since_ff <= since_ff + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_CTL_FIXED: assert property (
    rd_ctl |-> prdata[4] && prdata[31:8] == 24'h0)
    else $error("control fixed bits wrong");
  AST_CTL_RESET: assert property (
    rd_ctl && !ctl_wr_ff |-> prdata[7:0] == CTL_RESET)
    else $error("control reset value wrong");
  AST_MODE_STICKY: assert property (
    rd_ctl |-> prdata[7] == guard_ff) else $error("mode bit wrong");
  AST_FLAGS_RELOAD: assert property (
    rd_ctl && !prdata[7] |-> prdata[6:5] == 2'h0)
    else $error("guard flags set in reload mode");
  AST_RELOAD_SHADOW: assert property (
    rd_rel |-> prdata[7:0] == rl_ff) else $error("reload value wrong");
  AST_IRQ_PULSE: assert property (
    overflow_irq_flag |=> !overflow_irq_flag) else $error("irq too long");
  AST_RST_PULSE: assert property (
    $rose(system_reset_req) |=> $fell(system_reset_req))
    else $error("reset request too long");
  AST_IRQ_MODE: assert property (
    overflow_irq_flag |-> !guard_ff) else $error("irq in guard mode");
  AST_RST_MODE: assert property (
    system_reset_req |-> guard_ff) else $error("reset req in reload mode");
  AST_EVT_TICK: assert property (
    overflow_irq_flag || system_reset_req |-> since_ff <= 3'h4)
    else $error("event without a tick");
  // main scenarios
  cover property (overflow_irq_flag);
  cover property (system_reset_req);
  cover property (done && pslverr);
endmodule
`default_nettype wire

// [bench/rtwm_cpu_model.sv]
// apb master standing in for the processor core
`default_nettype none
module rtwm_cpu_model
  import rtwm_pkg::*;
(
  // clock
  input wire logic clk,
  // apb requests
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [rtwm_pkg::APB_ADDR_W-1:0] paddr,
  output logic [rtwm_pkg::APB_DATA_W-1:0] pwdata,
  output logic [3:0] pstrb,
  // answer and stall flag
  input wire logic pready,
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    hung = 1'b0;
    {pwrite, paddr, pwdata, pstrb} = '0;
  end
  // one transfer: setup, then access until pready or 20 cycles
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    hung <= (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the reload timer with guard mode
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtwm_pkg::*;
  logic clk = 0, srst = 1, ce = 1, tbc = 0;
  logic psel, penable, pwrite, pready, pslverr, irq, rreq, hung;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rs = 32'h1FB05DDA;
  logic [3:0] pstrb, strb = 4'hF;
  logic [16:0] notes[$];
  logic [16:0] nt;
  int err_count = 0, n_tests = 0, irq_cnt = 0, rst_cnt = 0;
  int divs[6] = '{1, 2, 4, 8, 32, 256};
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  rtwm_top rtwm_top_inst (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .time_base_clock(tbc), .overflow_irq_flag(irq), .system_reset_req(rreq));
  rtwm_cpu_model rtwm_cpu_model_inst (.clk(clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .hung(hung));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // note the expected answer, then run the transfer
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] m, input logic [7:0] e, input logic er);
    rs = xs(rs);
    notes.push_back({er, m, e});
    rtwm_cpu_model_inst.xfer(w, a, {rs[31:8], d}, strb);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, 8'hFF, e, 1'b0);
  endtask
  // exact number of time-base ticks, then let the pipeline settle
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      tbc <= 1'b1;
      @(posedge clk);
      tbc <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // answer watcher: each completed transfer meets the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      nt = notes.size() > 0 ? notes.pop_front() : '1;
      `CHK({pslverr, prdata[7:0] & nt[15:8]}, {nt[16], nt[7:0]})
    end
    irq_cnt += int'(irq === 1'b1);
    rst_cnt += int'(rreq === 1'b1);
  end
  // a stalled bus ends the run
  always @(posedge hung) begin
    err_count++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CONTROL, CTL_RESET);
    // reload mode: count write mirrors into reload, strobe-less write lost
    wr(OFS_COUNT, 8'h3A);
    rd(OFS_RELOAD, 8'h3A);
    wr(OFS_RELOAD, 8'hC5);
    rd(OFS_COUNT, 8'h3A);
    strb = 4'h0;
    wr(OFS_RELOAD, 8'h00);
    strb = 4'hF;
    rd(OFS_RELOAD, 8'hC5);
    wr(OFS_CONTROL, 8'h75);
    rd(OFS_CONTROL, 8'h15);
    acc(1'b0, 12'h00C, 8'h00, 8'h00, 8'h00, 1'b1);
    // each select: twice its ratio in ticks gives two counts, none halted
    foreach (divs[i]) begin
      wr(OFS_COUNT, 8'h10);
      wr(OFS_CONTROL, 8'h08 | 8'(i));
      pulses(2 * divs[i]);
      wr(OFS_CONTROL, 8'(i));
      pulses(2 * divs[i]);
      rd(OFS_COUNT, 8'h12);
    end
    // overflow wraps to the reload value and raises one request
    wr(OFS_COUNT, 8'hFD);
    wr(OFS_RELOAD, 8'h55);
    wr(OFS_CONTROL, 8'h08);
    // clock enable low: ticks in this gap must leave the count frozen
    ce <= 1'b0;
    pulses(4);
    ce <= 1'b1;
    pulses(4);
    wr(OFS_CONTROL, 8'h00);
    rd(OFS_COUNT, 8'h56);
    `CHK(irq_cnt, 1)
    // guard mode: period set first, then mode and select in one byte
    wr(OFS_COUNT, 8'hF0);
    wr(OFS_CONTROL, 8'h81);
    rd(OFS_CONTROL, 8'h91);
    wr(OFS_RELOAD, 8'h11);
    wr(OFS_CONTROL, 8'h0A);
    rd(OFS_RELOAD, 8'hF0);
    rd(OFS_CONTROL, 8'h99);
    pulses(4);
    rs = xs(rs);
    wr(OFS_COUNT, {rs[7:4], CODE_START});
    rd(OFS_COUNT, 8'hF0);
    rd(OFS_CONTROL, 8'hF9);
    wr(OFS_COUNT, 8'h53);
    pulses(10);
    rd(OFS_COUNT, 8'hF5);
    wr(OFS_COUNT, {rs[15:12], CODE_ALT});
    rd(OFS_COUNT, 8'hF0);
    rd(OFS_CONTROL, 8'hB9);
    pulses(32);
    `CHK(rst_cnt, 1)
    `CHK(irq_cnt, 1)
    // the system answers the request; control returns to its start
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CONTROL, CTL_RESET);
    // let the watcher meet the last answer before the verdict
    repeat (2) @(posedge clk);
    `CHK(notes.size(), 0)
    print_verdict;
  end
endmodule
bind rtwm_top rtwm_props rtwm_props_inst (.clk(clk), .srst(srst), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .time_base_clock(time_base_clock),
  .overflow_irq_flag(overflow_irq_flag), .system_reset_req(system_reset_req));
`default_nettype wire
